// [shared/rsv_pkg.sv]
// Package for the reset startup sequencer and vector map.
// Assumes a single 20 MHz clock; all delays are counts of that clock.
package rsv_pkg;

  // Clock rate.
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_NS = 50;

  // Program memory address layout.
  localparam int unsigned PM_ADDR_W = 24;
  localparam int unsigned PM_WORD_W = 16;
  localparam int unsigned PM_UPPER_IMPL_W = 8;
  localparam logic [23:0] PM_STEP = 24'h000002;
  localparam logic [23:0] PM_RESET_VEC = 24'h000000;
  localparam logic [23:0] PM_START_PTR = 24'h000002;
  localparam logic [23:0] PM_IVT_LO = 24'h000004;
  localparam logic [23:0] PM_IVT_HI = 24'h0000ff;
  localparam logic [23:0] PM_AIVT_LO = 24'h000100;
  localparam logic [23:0] PM_AIVT_HI = 24'h0001ff;
  localparam logic [23:0] PM_VEC_END = 24'h000200;
  localparam int unsigned IRQ_W = 7;

  // Delay figures in microseconds, as defaults for the top-level parameters.
  localparam int unsigned POWER_ON_DELAY_US = 10;
  localparam int unsigned BROWNOUT_DELAY_US = 10;
  localparam int unsigned MONITOR_START_DELAY_US = 10;
  localparam int unsigned OSC_DELAY_FAST_US = 1;
  localparam int unsigned OSC_DELAY_SLOW_US = 20;
  // Power-up timer period steps: 2^(sel-1) ms, sel = 0 means no timer.
  localparam int unsigned POWERUP_TIMER_BASE_US = 1000;

  // Derived cycle counts; least times round up.
  localparam int unsigned POWER_ON_CYC = (POWER_ON_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BROWNOUT_CYC = (BROWNOUT_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MONITOR_CYC = (MONITOR_START_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OSC_FAST_CYC = (OSC_DELAY_FAST_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OSC_SLOW_CYC = (OSC_DELAY_SLOW_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned POWERUP_BASE_CYC =
    (POWERUP_TIMER_BASE_US * 1000 + CLK_NS - 1) / CLK_NS;

  localparam int unsigned CNT_W = 32;

  // Startup sequence states.
  typedef enum logic [2:0] {
    RSV_POR,
    RSV_BOR,
    RSV_POWERUP_TIMER,
    RSV_OSC,
    RSV_RUN
  } rsv_state_t;

  // Fetch request carried to the core.
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
  } rsv_fetch_t;

  // Supply detector indications.
  typedef struct packed {
    logic power_on_threshold;
    logic brownout_threshold;
  } rsv_supply_t;

endpackage

// [verilog/rsv_delay.sv]
// Loadable up counter used for every startup delay stage.
// Assumes the caller asserts clear as each stage begins.
`timescale 1ns/10ps
module rsv_delay
  import rsv_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Control.
  input wire logic clear,
  input wire logic run,
  input wire logic [CNT_W-1:0] length,
  // Status.
  output logic done
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic done;
  } rsv_delay_st_t;

  rsv_delay_st_t st_reg;
  rsv_delay_st_t st_next;

  // Counts run cycles until the length is reached, then holds done.
  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next = '0;
    end else if (run && !st_reg.done) begin
      if (st_reg.count + 32'h00000001 >= length) begin
        st_next.done = 1'b1;
      end else begin
        st_next.count = st_reg.count + 32'h00000001;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done = st_reg.done;

endmodule

// [verilog/rsv_seq.sv]
// Startup sequencer and program counter model for a 16-bit core.
// Assumes analogue supply detectors and strap inputs arrive asynchronously.
//
// Overview of operation
// R1 - Program addresses are 24 bits; even lower word, odd upper word, top byte absent.
// R2 - Addresses stay lower-word aligned and step by two per instruction word.
// R3 - Range zero to 0x000200 is reserved for vectors, not ordinary code.
// R4 - Software places a jump at 0x000000 and its start address at 0x000002.
// R5 - Two vector tables, 0x000004-0x0000FF and 0x000100-0x0001FF, one entry per source.
// R6 - Hold reset until supply crosses power-on threshold and power-on delay expires.
// R7 - Hold reset until brown-out threshold crossed plus regulator delay.
// R8 - Power-up timer then holds reset its period; then system reset deasserts.
// R9 - Oscillator start-up delay, set by clock source, precedes clock ready.
// R10 - With clock ready the core fetches from address 0x000000.
// R11 - Enabled clock monitor starts only after clock ready plus its start delay.
// R12 - Any new reset restarts from the first stage, clearing all counters.
`timescale 1ns/10ps
module rsv_seq
  import rsv_pkg::*;
#(
  parameter int unsigned POWER_ON_CYCLES = POWER_ON_CYC,
  parameter int unsigned BROWNOUT_CYCLES = BROWNOUT_CYC,
  parameter int unsigned POWERUP_BASE_CYCLES = POWERUP_BASE_CYC,
  parameter int unsigned MONITOR_CYCLES = MONITOR_CYC,
  parameter int unsigned OSC_SLOW_CYCLES = OSC_SLOW_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Asynchronous supply and reset sources.
  input wire rsv_supply_t supply_async,
  input wire logic ext_reset_async,
  // Configuration straps, asynchronous.
  input wire logic [2:0] powerup_timer_sel_async,
  input wire logic osc_slow_source_async,
  input wire logic monitor_enable_async,
  // Core fetch interface.
  input wire logic core_advance,
  input wire logic core_backward,
  input wire logic core_jump,
  input wire logic [23:0] core_jump_addr,
  input wire logic irq_take,
  input wire logic irq_alt_table,
  input wire logic [IRQ_W-1:0] irq_num,
  // Sequencer outputs.
  output logic system_reset_line,
  output logic clock_ready,
  output logic clock_failure_monitor,
  output rsv_fetch_t fetch,
  output logic fetch_upper,
  output logic [23:0] upper_word_addr,
  output logic addr_fault
);

  // Whole state of the sequencer.
  typedef struct packed {
    rsv_state_t state;
    logic [23:0] program_counter;
    logic mon_wait;
    logic mon_on;
    logic [2:0] powerup_timer_sel;
    logic osc_slow;
    logic mon_en;
    logic fault;
  } rsv_st_t;

  rsv_st_t st_reg;
  rsv_st_t st_next;

  // Synchroniser chains for every asynchronous input.
  localparam int unsigned SYNC_W = 8;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] async_bus;
  assign async_bus = {supply_async, ext_reset_async, powerup_timer_sel_async,
    osc_slow_source_async, monitor_enable_async};

  // Two flip-flop synchroniser; only the second stage is read.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= async_bus;
      sync2_reg <= sync1_reg;
    end
  end

  logic por_ok;
  logic bor_ok;
  logic ext_rst;
  logic [2:0] sel_s;
  logic slow_s;
  logic mon_s;
  assign por_ok = sync2_reg[7];
  assign bor_ok = sync2_reg[6];
  assign ext_rst = sync2_reg[5];
  assign sel_s = sync2_reg[4:2];
  assign slow_s = sync2_reg[1];
  assign mon_s = sync2_reg[0];

  // Any reason to start over from the first stage.
  logic restart;
  assign restart = ext_rst || !por_ok || !bor_ok; // R12

  // Returns the aligned vector address for an interrupt source.
  function automatic logic [23:0] vec_addr(input logic alt, input logic [IRQ_W-1:0] n);
    logic [23:0] base;
    base = alt ? PM_AIVT_LO : PM_IVT_LO;
    vec_addr = base + {16'h0000, n, 1'b0};
  endfunction

  // Shared delay counter, one stage at a time.
  logic stage_run;
  logic stage_done;
  logic stage_clear;
  logic [CNT_W-1:0] stage_len;
  rsv_state_t prev_state_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_state_reg <= RSV_POR;
    end else begin
      prev_state_reg <= st_reg.state;
    end
  end

  // The counter restarts on every stage change and on every restart.
  assign stage_clear = restart || (prev_state_reg != st_reg.state); // R12
  assign stage_run = (st_reg.state != RSV_RUN) || st_reg.mon_wait;

  // Selects the length of the running stage.
  always_comb begin
    case (st_reg.state)
      RSV_POR: stage_len = POWER_ON_CYCLES; // R6
      RSV_BOR: stage_len = BROWNOUT_CYCLES; // R7
      RSV_POWERUP_TIMER: stage_len = POWERUP_BASE_CYCLES << (st_reg.powerup_timer_sel - 3'h1); // R8
      RSV_OSC: stage_len = st_reg.osc_slow ? OSC_SLOW_CYCLES : OSC_FAST_CYC; // R9
      RSV_RUN: stage_len = MONITOR_CYCLES; // R11
      default: stage_len = POWER_ON_CYCLES;
    endcase
  end

  rsv_delay u_delay (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(stage_clear),
    .run(stage_run),
    .length(stage_len),
    .done(stage_done)
  );

  // Next-state logic for the sequence and the program counter.
  always_comb begin
    st_next = st_reg;
    if (restart) begin
      st_next.state = RSV_POR; // R12
      st_next.program_counter = PM_RESET_VEC;
      st_next.mon_wait = 1'b0;
      st_next.mon_on = 1'b0;
      st_next.fault = 1'b0;
    end else begin
      case (st_reg.state)
        RSV_POR: begin
          if (stage_done && !stage_clear) begin
            st_next.state = RSV_BOR; // R6
          end
        end
        RSV_BOR: begin
          if (stage_done && !stage_clear) begin
            // Straps are captured once the regulator is stable.
            st_next.powerup_timer_sel = sel_s;
            st_next.osc_slow = slow_s;
            st_next.mon_en = mon_s;
            st_next.state = (sel_s == 3'h0) ? RSV_OSC : RSV_POWERUP_TIMER; // R7
          end
        end
        RSV_POWERUP_TIMER: begin
          if (stage_done && !stage_clear) begin
            st_next.state = RSV_OSC; // R8
          end
        end
        RSV_OSC: begin
          if (stage_done && !stage_clear) begin
            st_next.state = RSV_RUN; // R9
            st_next.program_counter = PM_RESET_VEC; // R10
            st_next.mon_wait = st_reg.mon_en;
          end
        end
        RSV_RUN: begin
          if (st_reg.mon_wait && stage_done && !stage_clear) begin
            st_next.mon_wait = 1'b0;
            st_next.mon_on = 1'b1; // R11
          end
          if (irq_take) begin
            st_next.program_counter = vec_addr(irq_alt_table, irq_num); // R5
          end else if (core_jump) begin
            // Low address bit is dropped to keep lower-word alignment.
            st_next.program_counter = {core_jump_addr[23:1], 1'b0}; // R2
            if ({core_jump_addr[23:1], 1'b0} < PM_VEC_END) begin
              st_next.fault = 1'b1; // R3
            end
          end else if (core_advance) begin
            st_next.program_counter = core_backward ?
              st_reg.program_counter - PM_STEP :
              st_reg.program_counter + PM_STEP; // R2
          end
        end
        default: st_next.state = RSV_POR;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '{state: RSV_POR, program_counter: 24'h000000, mon_wait: 1'b0,
        mon_on: 1'b0, powerup_timer_sel: 3'h0, osc_slow: 1'b0, mon_en: 1'b0, fault: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // System reset is released from the oscillator stage on.
  assign system_reset_line = (st_reg.state == RSV_POR) || (st_reg.state == RSV_BOR) ||
    (st_reg.state == RSV_POWERUP_TIMER); // R8
  assign clock_ready = (st_reg.state == RSV_RUN); // R9
  assign clock_failure_monitor = st_reg.mon_on; // R11
  assign fetch.valid = (st_reg.state == RSV_RUN); // R10
  assign fetch.addr = st_reg.program_counter; // R1
  // The upper word sits at the odd address; only its low byte is implemented.
  assign fetch_upper = fetch.valid; // R1
  assign upper_word_addr = {st_reg.program_counter[23:1], 1'b1}; // R1
  // Flags a jump target inside the vector area; the reset jump lives at R4 offsets.
  assign addr_fault = st_reg.fault; // R3

endmodule

// [tb/rsv_seq_sva.sv]
// Port checks for the startup sequencer.
// Assumes a bind onto rsv_seq.
`timescale 1ns/10ps
module rsv_seq_sva
  import rsv_pkg::*;
#(
  parameter int unsigned POWER_ON_CYCLES = 4,
  parameter int unsigned BROWNOUT_CYCLES = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Inputs.
  input wire rsv_supply_t supply_async,
  input wire logic core_advance,
  input wire logic core_backward,
  input wire logic core_jump,
  input wire logic [23:0] core_jump_addr,
  input wire logic irq_take,
  input wire logic irq_alt_table,
  input wire logic [IRQ_W-1:0] irq_num,
  // Outputs.
  input wire logic system_reset_line,
  input wire logic clock_ready,
  input wire logic clock_failure_monitor,
  input wire rsv_fetch_t fetch,
  input wire logic [23:0] upper_word_addr,
  input wire logic addr_fault
);
  logic [15:0] hold_cnt;
  logic step;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A plain step request that nothing of higher priority overrides.
  assign step = clock_ready && core_advance && !core_jump && !irq_take;
  // Counts the cycles of one reset hold.
  always_ff @(posedge clk) begin
    hold_cnt <= (sys_rst || !system_reset_line) ? 16'h0000 : hold_cnt + 16'h0001;
  end
  a_upper_odd: assert property (upper_word_addr == (fetch.addr | 24'h000001))
    else $error("upper word address wrong");
  a_addr_even: assert property (fetch.addr[0] == 1'b0)
    else $error("address not even");
  a_step_up: assert property (step && !core_backward |=>
    !clock_ready || fetch.addr == $past(fetch.addr) + PM_STEP) else $error("bad up step");
  a_step_down: assert property (step && core_backward |=>
    !clock_ready || fetch.addr == $past(fetch.addr) - PM_STEP) else $error("bad down step");
  a_vec_fault: assert property (clock_ready && core_jump && !irq_take &&
    core_jump_addr < PM_VEC_END |=> addr_fault || !clock_ready) else $error("no fault");
  a_irq_entry: assert property (clock_ready && irq_take |=> !clock_ready ||
    fetch.addr == ($past(irq_alt_table) ? PM_AIVT_LO : PM_IVT_LO) + {$past(irq_num), 1'b0})
    else $error("bad vector");
  a_hold_min: assert property ($fell(system_reset_line) |->
    hold_cnt >= POWER_ON_CYCLES + BROWNOUT_CYCLES) else $error("hold too short");
  a_ready_free: assert property (clock_ready |-> !system_reset_line)
    else $error("ready in reset");
  a_fetch_zero: assert property ($rose(clock_ready) |->
    fetch.addr == PM_RESET_VEC && !addr_fault) else $error("bad start fetch");
  a_monitor_late: assert property ($rose(clock_ready) |-> !clock_failure_monitor [*2])
    else $error("monitor early");
  a_restart_hold: assert property ((!supply_async.brownout_threshold) [*5] |->
    system_reset_line && !clock_ready && !clock_failure_monitor) else $error("no restart");
  c_ready: cover property ($rose(clock_ready));
  c_monitor: cover property ($rose(clock_failure_monitor));
  c_alt_irq: cover property (clock_ready && irq_take && irq_alt_table);
endmodule

// [tb/rsv_core_model.sv]
// Core model: takes the jump behind the reset vector, then steps on request.
// Assumes clock_ready stays low until code may run.
`timescale 1ns/10ps
module rsv_core_model
  import rsv_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Sequencer side.
  input wire logic clock_ready,
  input wire rsv_fetch_t fetch,
  output logic core_advance,
  output logic core_jump,
  output logic [23:0] core_jump_addr,
  // Bench control.
  input wire logic run,
  input wire logic [23:0] start_addr
);
  logic booted;
  // The jump target toggles when unused so a stale value never looks valid.
  always_ff @(posedge clk) begin
    core_jump <= 1'b0;
    core_advance <= 1'b0;
    core_jump_addr <= sys_rst ? 24'h000000 : ~core_jump_addr;
    if (sys_rst || !clock_ready) begin
      booted <= 1'b0;
    end else if (!booted && fetch.addr == PM_RESET_VEC) begin
      booted <= 1'b1;
      core_jump <= 1'b1;
      core_jump_addr <= start_addr;
    end else begin
      core_advance <= run;
    end
  end
endmodule

// [tb/rsv_seq_tb.sv]
// Bench for the startup sequencer driving a core model.
// Assumes small delay parameters so each boot is short.
`timescale 1ns/10ps
module rsv_seq_tb;
  import rsv_pkg::*;
  localparam int unsigned DLY = 4;
  logic clk, sys_rst, ext_reset_async, osc_slow_source_async, monitor_enable_async, run;
  logic core_backward, irq_take, irq_alt_table, core_advance, core_jump, fetch_upper;
  logic system_reset_line, clock_ready, clock_failure_monitor, addr_fault;
  logic [2:0] powerup_timer_sel_async;
  logic [IRQ_W-1:0] irq_num;
  logic [23:0] core_jump_addr, start_addr, upper_word_addr;
  rsv_supply_t supply_async;
  rsv_fetch_t fetch;
  int fails, samples_checked, cyc;
  rsv_seq #(.POWER_ON_CYCLES(DLY), .BROWNOUT_CYCLES(DLY), .POWERUP_BASE_CYCLES(DLY),
    .MONITOR_CYCLES(DLY), .OSC_SLOW_CYCLES(DLY)) i_rsv_seq (.*);
  rsv_core_model i_rsv_core_model (.*);
  // Clock source.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  // Compares one value and counts it.
  task chk_val(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checked %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Powers up with the given straps and checks each stage.
  task boot(input logic [2:0] sel, input logic slow, input logic mon, input logic [23:0] st);
    int n;
    int k;
    @(posedge clk);
    powerup_timer_sel_async <= sel;
    osc_slow_source_async <= slow;
    monitor_enable_async <= mon;
    start_addr <= st;
    supply_async <= 2'b11;
    ext_reset_async <= 1'b0;
    n = 0;
    k = 0;
    while (system_reset_line !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    chk_val(n >= 2 * DLY + ((sel == 3'h0) ? 0 : (DLY << (sel - 3'h1))), 1);
    while (clock_ready !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1 k++;
    end
    chk_val(k >= (slow ? DLY : OSC_FAST_CYC), 1);
    chk_val(fetch.addr, PM_RESET_VEC);
    chk_val({fetch_upper, fetch.valid}, 24'h000003);
    chk_val(clock_failure_monitor, 0);
    repeat (2) @(posedge clk);
    #1 chk_val(fetch.addr, st);
    repeat (3 * DLY) @(posedge clk);
    #1 chk_val(clock_failure_monitor, mon);
    chk_val(addr_fault, st < PM_VEC_END);
    chk_val(upper_word_addr, st | 24'h000001);
  endtask
  // Three steps up, then two down.
  task walk;
    logic [23:0] a;
    a = fetch.addr;
    @(posedge clk);
    run <= 1'b1;
    repeat (3) @(posedge clk);
    run <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk_val(fetch.addr, a + 24'h000006);
    @(posedge clk);
    core_backward <= 1'b1;
    run <= 1'b1;
    repeat (2) @(posedge clk);
    run <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk_val(upper_word_addr, a + 24'h000003);
    @(posedge clk);
    core_backward <= 1'b0;
  endtask
  // Takes one interrupt and checks its vector.
  task irq(input logic alt, input logic [IRQ_W-1:0] num, input logic [23:0] exp);
    @(posedge clk);
    irq_take <= 1'b1;
    irq_alt_table <= alt;
    irq_num <= num;
    @(posedge clk);
    irq_take <= 1'b0;
    #1 chk_val(fetch.addr, exp);
  endtask
  // Raises a reset source, checks the outputs six cycles later and leaves it raised.
  task restart(input logic use_ext);
    @(posedge clk);
    if (use_ext) begin
      ext_reset_async <= 1'b1;
    end else begin
      supply_async <= 2'b10;
    end
    repeat (6) @(posedge clk);
    #1 chk_val(system_reset_line, 1);
    chk_val(clock_ready | clock_failure_monitor | addr_fault, 0);
    chk_val({fetch_upper, fetch.valid}, 24'h000000);
  endtask
  // Main sequence.
  initial begin
    {sys_rst, ext_reset_async, osc_slow_source_async, monitor_enable_async, run} = 5'h10;
    {core_backward, irq_take, irq_alt_table, irq_num, powerup_timer_sel_async} = 13'h0000;
    supply_async = 2'b00;
    start_addr = 24'h000400;
    fails = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    boot(3'h1, 1'b1, 1'b1, 24'h000400);
    walk;
    irq(1'b0, 7'h00, 24'h000004);
    irq(1'b0, 7'h05, 24'h00000e);
    irq(1'b1, 7'h7f, 24'h0001fe);
    restart(1'b1);
    boot(3'h2, 1'b0, 1'b0, 24'h000100);
    restart(1'b0);
    @(posedge clk);
    supply_async <= 2'b11;
    repeat (DLY + 3) @(posedge clk);
    restart(1'b0);
    boot(3'h0, 1'b1, 1'b0, 24'h000200);
    end_sim;
  end
endmodule
bind rsv_seq rsv_seq_sva #(.POWER_ON_CYCLES(POWER_ON_CYCLES),
  .BROWNOUT_CYCLES(BROWNOUT_CYCLES)) i_rsv_seq_sva (.*);
